//--- core/lpm_controller.sv
// low-power mode controller: run/sleep/stop/standby sequencing with axi4-lite registers
// assumes wakeup sources and core handshakes are synchronous to clock
//
// The placing of the registers and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/10ps
module lpm_controller
  import lpm_pkg::*;
#(
  parameter int unsigned LINES      = EXT_LINES,
  parameter int unsigned SETTLE_CYC = REG_SETTLE_CYC
) (
  input  wire logic             clock,
  input  wire logic             srst,
  // axi4-lite slave
  input  wire logic [7:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [7:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  // processor core
  input  wire logic             cpu_wfi,
  input  wire logic             periph_irq,
  // wakeup sources
  input  wire logic [LINES-1:0] external_event_lines,
  input  wire logic             supply_voltage_detector_out,
  input  wire logic             rtc_alarm,
  input  wire logic             external_reset_pin_n,
  input  wire logic             independent_watchdog_rst,
  input  wire logic             wakeup_pin,
  // power domain controls
  output logic                  cpu_clk_en,
  output logic                  periph_clk_en,
  output logic                  core_clk_en,
  output logic                  pll_en,
  output logic                  internal_fast_rc_oscillator_en,
  output logic                  external_fast_crystal_oscillator_en,
  output logic                  slow_clk_en,
  output logic                  main_regulator_en,
  output logic                  low_power_regulator_en,
  output logic                  regulator_hiz,
  output logic                  supply_voltage_detector_en,
  output logic                  core_reset,
  output logic [4:0]            power_state
);

  pwr_state_e state_r, state_nxt;

  logic [31:0]      ctrl_r;
  logic [LINES-1:0] lmask_r;
  logic [1:0]       wflag_r;
  logic [15:0]      settle_r;
  logic             aw_got_r, w_got_r;
  logic [7:0]       awaddr_r;
  logic [31:0]      wdata_r;
  logic [3:0]       wstrb_r;
  logic             stop_wake, stdby_wake;

  lpm_wake_sources #(
    .LINES(LINES)
  ) u_wake (
    .clock                       (clock),
    .srst                        (srst),
    .external_event_lines        (external_event_lines),
    .line_mask                   (lmask_r),
    .supply_voltage_detector_out (supply_voltage_detector_out),
    .svd_enable                  (ctrl_r[CTRL_SVD_EN_BIT]),
    .rtc_alarm                   (rtc_alarm),
    .external_reset_pin_n        (external_reset_pin_n),
    .independent_watchdog_rst    (independent_watchdog_rst),
    .wakeup_pin                  (wakeup_pin),
    .wakeup_pin_en               (ctrl_r[CTRL_WKPIN_BIT]),
    .stop_wake                   (stop_wake),
    .stdby_wake                  (stdby_wake)
  );

  // mode request: the core announces wait-for-interrupt while a mode is selected
  wire req_sleep = cpu_wfi & ctrl_r[CTRL_SLEEP_BIT] & ~ctrl_r[CTRL_DEEP_BIT];
  wire req_stop  = cpu_wfi & ctrl_r[CTRL_DEEP_BIT] & ~ctrl_r[CTRL_STDBY_BIT];
  wire req_stdby = cpu_wfi & ctrl_r[CTRL_DEEP_BIT] & ctrl_r[CTRL_STDBY_BIT];
  wire settle_done = (settle_r == 16'(SETTLE_CYC));

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: begin
        if (req_stdby) begin
          state_nxt = ST_STDBY;
        end else if (req_stop) begin
          state_nxt = ST_STOP;
        end else if (req_sleep) begin
          state_nxt = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (periph_irq | stop_wake) begin
          state_nxt = ST_RUN;
        end
      end
      ST_STOP: begin
        if (stop_wake) begin
          state_nxt = ST_RUN;
        end
      end
      ST_STDBY: begin
        if (stdby_wake) begin
          state_nxt = ST_BOOT;
        end
      end
      ST_BOOT: begin
        if (settle_done) begin
          state_nxt = ST_RUN;
        end
      end
      default: state_nxt = ST_BOOT;
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state_r <= ST_BOOT;
    end else begin
      state_r <= state_nxt;
    end
  end

  // regulator settle counter; also covers power-on
  always_ff @(posedge clock) begin
    if (srst || state_r != ST_BOOT) begin
      settle_r <= 16'h0000;
    end else if (!settle_done) begin
      settle_r <= settle_r + 16'h0001;
    end
  end

  wire in_run   = (state_r == ST_RUN);
  wire in_sleep = (state_r == ST_SLEEP);
  wire in_stop  = (state_r == ST_STOP);
  wire in_stdby = (state_r == ST_STDBY);
  wire in_boot  = (state_r == ST_BOOT);
  wire stop_lp  = ctrl_r[CTRL_LPREG_BIT];

  // outputs from flops so clock gates never see decode glitches
  always_ff @(posedge clock) begin
    if (srst) begin
      cpu_clk_en                          <= 1'b0;
      periph_clk_en                       <= 1'b0;
      core_clk_en                         <= 1'b0;
      pll_en                              <= 1'b0;
      internal_fast_rc_oscillator_en      <= 1'b1;
      external_fast_crystal_oscillator_en <= 1'b0;
      slow_clk_en                         <= 1'b1;
      main_regulator_en                   <= 1'b1;
      low_power_regulator_en              <= 1'b0;
      regulator_hiz                       <= 1'b0;
      core_reset                          <= 1'b1;
    end else begin
      cpu_clk_en                          <= in_run;
      periph_clk_en                       <= in_run | in_sleep;
      core_clk_en                         <= in_run | in_sleep;
      pll_en                              <= in_run | in_sleep;
      internal_fast_rc_oscillator_en      <= ~(in_stop | in_stdby);
      external_fast_crystal_oscillator_en <= in_run | in_sleep;
      slow_clk_en                         <= 1'b1;
      // stop keeps the main regulator unless low-power is selected
      main_regulator_en                   <= in_run | in_sleep | in_boot | (in_stop & ~stop_lp);
      low_power_regulator_en              <= in_stop & stop_lp;
      regulator_hiz                       <= in_stdby;
      core_reset                          <= in_stdby | in_boot;
    end
  end

  assign power_state = state_r;
  // detector stays off until software enables it
  assign supply_voltage_detector_en = ctrl_r[CTRL_SVD_EN_BIT];

  // axi4-lite write path: address and data taken in either order
  assign s_axi_awready = ~aw_got_r & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_got_r & ~s_axi_bvalid;
  wire aw_hs   = s_axi_awvalid & s_axi_awready;
  wire w_hs    = s_axi_wvalid & s_axi_wready;
  wire wr_go   = aw_got_r & w_got_r;
  wire [31:0] wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
  wire [31:0] ctrl_w = (ctrl_r & ~wmask) | (wdata_r & wmask);
  wire [31:0] lm_w  = ({{(32-LINES){1'b0}}, lmask_r} & ~wmask) | (wdata_r & wmask);
  wire wr_ctrl  = wr_go & (awaddr_r == CTRL_OFS);
  wire wr_lmask = wr_go & (awaddr_r == LMASK_OFS);
  wire wr_wflag = wr_go & (awaddr_r == WFLAG_OFS);
  wire wr_ok    = wr_ctrl | wr_lmask | wr_wflag | (awaddr_r == STATUS_OFS);

  // wake flags: hardware set wins over a write-one-to-clear in the same cycle
  wire [1:0] wf_set = {in_stdby & stdby_wake, in_stop & stop_wake};
  wire [1:0] wf_clr = wr_wflag ? (wdata_r[1:0] & {2{wstrb_r[0]}}) : 2'b00;

  always_ff @(posedge clock) begin
    if (srst) begin
      aw_got_r     <= 1'b0;
      w_got_r      <= 1'b0;
      awaddr_r     <= 8'h00;
      wdata_r      <= 32'h0000_0000;
      wstrb_r      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
      ctrl_r       <= CTRL_RST;
      lmask_r      <= LMASK_RST;
      wflag_r      <= 2'b00;
    end else begin
      if (aw_hs) begin
        aw_got_r <= 1'b1;
        awaddr_r <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (w_hs) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_got_r     <= 1'b0;
        w_got_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_ctrl) begin
        ctrl_r <= {26'h000_0000, ctrl_w[5:0]};
      end
      if (wr_lmask) begin
        lmask_r <= lm_w[LINES-1:0];
      end
      wflag_r <= (wflag_r & ~wf_clr) | wf_set;
    end
  end

  // axi4-lite read path
  assign s_axi_arready = ~s_axi_rvalid;
  wire [7:0] ra = {s_axi_araddr[7:2], 2'b00};
  wire rd_hit = (ra == CTRL_OFS) | (ra == STATUS_OFS) | (ra == LMASK_OFS) | (ra == WFLAG_OFS);
  wire [31:0] rd_mux =
    (ra == CTRL_OFS)   ? ctrl_r :
    (ra == STATUS_OFS) ? {20'h0_0000, 2'b00, regulator_hiz, low_power_regulator_en,
                          main_regulator_en, 2'b00, state_r} :
    (ra == LMASK_OFS)  ? {{(32-LINES){1'b0}}, lmask_r} :
    (ra == WFLAG_OFS)  ? {30'h0000_0000, wflag_r} : 32'h0000_0000;

  always_ff @(posedge clock) begin
    if (srst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

//--- include/lpm_pkg.sv
// constants, state encodings and register map of the low-power mode controller
// assumes a 32-bit axi4-lite register bus and a single 250 MHz clock
package lpm_pkg;

  localparam int unsigned CLK_MHZ          = 250;
  // regulator settle time after a standby exit before the core is released
  localparam int unsigned REG_SETTLE_US    = 2;
  localparam int unsigned REG_SETTLE_CYC   = REG_SETTLE_US * CLK_MHZ;
  localparam int unsigned EXT_LINES        = 16;

  // register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] LMASK_OFS  = 8'h08;
  localparam logic [7:0] WFLAG_OFS  = 8'h0C;

  // control register fields
  localparam int unsigned CTRL_SLEEP_BIT   = 0;  // request sleep
  localparam int unsigned CTRL_DEEP_BIT    = 1;  // 1: deep (stop/standby) on request
  localparam int unsigned CTRL_STDBY_BIT   = 2;  // deep means standby when set
  localparam int unsigned CTRL_LPREG_BIT   = 3;  // stop uses low-power regulator
  localparam int unsigned CTRL_SVD_EN_BIT  = 4;  // supply voltage detector enable
  localparam int unsigned CTRL_WKPIN_BIT   = 5;  // wakeup pin enable
  localparam logic [31:0] CTRL_RST         = 32'h0000_0000;
  localparam logic [15:0] LMASK_RST        = 16'h0000;

  // wake flag register fields
  localparam int unsigned WF_STOP_BIT  = 0;
  localparam int unsigned WF_STDBY_BIT = 1;

  // regulator mode codes
  localparam logic [1:0] REG_MAIN = 2'b00;
  localparam logic [1:0] REG_LP   = 2'b01;
  localparam logic [1:0] REG_OFF  = 2'b10;

  typedef enum logic [4:0] {
    ST_RUN   = 5'b00001,
    ST_SLEEP = 5'b00010,
    ST_STOP  = 5'b00100,
    ST_STDBY = 5'b01000,
    ST_BOOT  = 5'b10000
  } pwr_state_e;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

//--- core/lpm_wake_sources.sv
// wakeup source collector: qualifies stop-mode event lines and standby events
// assumes all inputs are synchronous to clock
`timescale 1ns/10ps
module lpm_wake_sources
  import lpm_pkg::*;
#(
  parameter int unsigned LINES = EXT_LINES
) (
  input  wire logic             clock,
  input  wire logic             srst,
  input  wire logic [LINES-1:0] external_event_lines,
  input  wire logic [LINES-1:0] line_mask,
  input  wire logic             supply_voltage_detector_out,
  input  wire logic             svd_enable,
  input  wire logic             rtc_alarm,
  input  wire logic             external_reset_pin_n,
  input  wire logic             independent_watchdog_rst,
  input  wire logic             wakeup_pin,
  input  wire logic             wakeup_pin_en,
  output logic                  stop_wake,
  output logic                  stdby_wake
);

  logic             wkpin_prev_r;
  logic [LINES-1:0] line_hit;

  genvar g;
  generate
    for (g = 0; g < LINES; g++) begin : g_line
      assign line_hit[g] = external_event_lines[g] & line_mask[g];
    end
  endgenerate

  // detector only counts once software has enabled it
  assign stop_wake = (|line_hit) | (supply_voltage_detector_out & svd_enable) | rtc_alarm;

  wire wkpin_rise = wakeup_pin & ~wkpin_prev_r & wakeup_pin_en;
  assign stdby_wake = ~external_reset_pin_n | independent_watchdog_rst | wkpin_rise | rtc_alarm;

  always_ff @(posedge clock) begin
    if (srst) begin
      wkpin_prev_r <= 1'b1;
    end else begin
      wkpin_prev_r <= wakeup_pin;
    end
  end

endmodule

//--- testbench/lpm_controller_props.sv
// assertions on the power outputs of the low-power mode controller
// assumes it is bound to lpm_controller and sees only its ports
`timescale 1ns/10ps
module lpm_controller_props
  import lpm_pkg::*;
(
  input wire logic       clock,
  input wire logic       srst,
  input wire logic       periph_irq,
  input wire logic       rtc_alarm,
  input wire logic       external_reset_pin_n,
  input wire logic       independent_watchdog_rst,
  input wire logic       cpu_clk_en,
  input wire logic       periph_clk_en,
  input wire logic       core_clk_en,
  input wire logic       pll_en,
  input wire logic       internal_fast_rc_oscillator_en,
  input wire logic       external_fast_crystal_oscillator_en,
  input wire logic       slow_clk_en,
  input wire logic       main_regulator_en,
  input wire logic       low_power_regulator_en,
  input wire logic       regulator_hiz,
  input wire logic       core_reset,
  input wire logic [4:0] power_state
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // outputs trail the state by one edge, so a mode counts once held for two
  sequence held(logic [4:0] s);
    (power_state == s) [*2];
  endsequence
  a_sleep_cpu_only: assert property (held(ST_SLEEP) |-> !cpu_clk_en && periph_clk_en)
    else $error("sleep gating wrong");
  a_sleep_wake: assert property (power_state == ST_SLEEP && periph_irq |-> ##[1:2] power_state == ST_RUN)
    else $error("sleep not ended by irq");
  a_stop_clocks: assert property (held(ST_STOP) |-> !core_clk_en && !pll_en &&
    !internal_fast_rc_oscillator_en && !external_fast_crystal_oscillator_en) else $error("stop clocks running");
  a_stop_reg: assert property (held(ST_STOP) |-> (main_regulator_en != low_power_regulator_en) && !regulator_hiz)
    else $error("stop regulator wrong");
  a_stop_wake: assert property (power_state == ST_STOP && rtc_alarm |-> ##[1:2] power_state == ST_RUN)
    else $error("stop not ended by alarm");
  a_stdby_off: assert property (held(ST_STDBY) |-> !main_regulator_en && !low_power_regulator_en && regulator_hiz)
    else $error("standby regulator on");
  a_stdby_exit: assert property (power_state == ST_STDBY && (!external_reset_pin_n || independent_watchdog_rst
    || rtc_alarm) |-> ##[1:2] power_state == ST_BOOT) else $error("standby not ended");
  a_slow_runs: assert property (held(ST_STOP) or held(ST_STDBY) |-> slow_clk_en)
    else $error("slow clock stopped");
  a_run_main: assert property (held(ST_RUN) |-> main_regulator_en && !low_power_regulator_en && !regulator_hiz)
    else $error("run regulator wrong");
  a_reset_reg: assert property ($fell(srst) |-> main_regulator_en && core_reset)
    else $error("regulator off after reset");
  a_boot_reset: assert property (held(ST_BOOT) |-> core_reset && main_regulator_en)
    else $error("boot without core reset");
endmodule
bind lpm_controller lpm_controller_props u_props (.clock, .srst, .periph_irq, .rtc_alarm, .external_reset_pin_n,
  .independent_watchdog_rst, .cpu_clk_en, .periph_clk_en, .core_clk_en, .pll_en, .internal_fast_rc_oscillator_en,
  .external_fast_crystal_oscillator_en, .slow_clk_en, .main_regulator_en, .low_power_regulator_en, .regulator_hiz,
  .core_reset, .power_state);

//--- testbench/lpm_far_side.sv
// model of the core and the wakeup sources facing the controller
// assumes req and go are pulsed by the bench just after a rising edge
`timescale 1ns/10ps
module lpm_far_side
  import lpm_pkg::*;
(
  input  wire logic        clock,
  input  wire logic [4:0]  power_state,
  input  wire logic        req,
  input  wire logic        go,
  input  wire logic [2:0]  src,
  output logic             cpu_wfi,
  output logic             periph_irq,
  output logic [15:0]      external_event_lines,
  output logic             supply_voltage_detector_out,
  output logic             rtc_alarm,
  output logic             external_reset_pin_n,
  output logic             independent_watchdog_rst,
  output logic             wakeup_pin
);
  logic [1:0] hold_r;
  logic [2:0] src_r;
  initial begin
    cpu_wfi = 1'b0;
    hold_r  = 2'd0;
    src_r   = 3'd0;
  end
  // wait request stays up until the mode is taken, as a sleeping core would
  always @(posedge clock) begin
    if (req) cpu_wfi <= 1'b1;
    else if (power_state != ST_RUN) cpu_wfi <= 1'b0;
    hold_r <= go ? 2'd3 : hold_r - {1'b0, hold_r != 2'd0};
    if (go) src_r <= src;
  end
  wire act = hold_r != 2'd0;
  assign periph_irq                  = act && src_r == 3'd0;
  assign external_event_lines        = {10'h000, act && src_r == 3'd1, 5'h00};
  assign supply_voltage_detector_out = act && src_r == 3'd2;
  assign rtc_alarm                   = act && src_r == 3'd3;
  // reset pin has a pull-up, so it idles high
  assign external_reset_pin_n        = !(act && src_r == 3'd4);
  assign independent_watchdog_rst    = act && src_r == 3'd5;
  assign wakeup_pin                  = act && src_r == 3'd6;
endmodule

//--- testbench/low_power_mode_controller_tb.sv
// self-checking bench: axi4-lite register tasks and mode sequences
// assumes lpm_controller, lpm_far_side and the bound checker
`timescale 1ns/10ps
module low_power_mode_controller_tb
  import lpm_pkg::*;
;
  logic clock, srst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, req, go;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [2:0] src;
  logic [1:0] rsp;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire cpu_wfi, periph_irq, supply_voltage_detector_out, rtc_alarm, external_reset_pin_n;
  wire independent_watchdog_rst, wakeup_pin, cpu_clk_en, periph_clk_en, core_clk_en, pll_en, slow_clk_en;
  wire internal_fast_rc_oscillator_en, external_fast_crystal_oscillator_en, main_regulator_en;
  wire low_power_regulator_en, regulator_hiz, supply_voltage_detector_en, core_reset;
  wire [15:0] external_event_lines;
  wire [4:0] power_state;
  int bad_count, n_checks;
  // short regulator settle keeps the boot phase brief
  lpm_controller #(.LINES(16), .SETTLE_CYC(4)) u_dut (.*);
  lpm_far_side u_far (.*);
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 0;
    w_ok = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clock);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok = 1;
        s_axi_awvalid <= 0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok = 1;
        s_axi_wvalid <= 0;
      end
    end
    do @(posedge clock); while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge clock); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    do @(posedge clock); while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  task automatic wait_st(input logic [4:0] s);
    int i;
    i = 0;
    while (power_state !== s && i < 2000) begin
      @(posedge clock);
      i++;
    end
    check(power_state, s);
  endtask
  task automatic go_mode(input logic [31:0] ctrl, input logic [4:0] s);
    axi_wr(CTRL_OFS, ctrl);
    req <= 1;
    @(posedge clock);
    req <= 0;
    wait_st(s);
    repeat (2) @(posedge clock);
  endtask
  task automatic fire(input logic [2:0] s);
    src <= s;
    go <= 1;
    @(posedge clock);
    go <= 0;
  endtask
  initial begin
    #200000;
    bad_count++;
    close_out();
  end
  initial begin
    srst = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, req, go} = 7'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, src} = 51'h0;
    s_axi_wstrb = 4'hf;
    repeat (20) @(posedge clock);
    check({main_regulator_en, core_reset}, 2'b11);
    srst <= 0;
    wait_st(ST_RUN);
    repeat (2) @(posedge clock);
    check({cpu_clk_en, main_regulator_en, core_reset}, 3'b110);
    axi_rd(STATUS_OFS);
    check(rd, 32'h0000_0081);
    axi_rd(CTRL_OFS);
    check(rd, CTRL_RST);
    axi_wr(LMASK_OFS, 32'h0000_0020);
    axi_rd(LMASK_OFS);
    check(rd, 32'h0000_0020);
    axi_rd(8'h10);
    check({rsp, rd}, {RESP_SLVERR, 32'h0000_0000});
    axi_wr(8'h14, 32'h0000_ffff);
    check(rsp, RESP_SLVERR);
    go_mode(32'h0000_0001, ST_SLEEP);
    check({cpu_clk_en, periph_clk_en, main_regulator_en}, 3'b011);
    fire(3'd0);
    wait_st(ST_RUN);
    for (int i = 1; i <= 3; i++) begin
      // detector enabled by software, else its output would not wake
      go_mode(i % 2 ? 32'h0000_001a : 32'h0000_0012, ST_STOP);
      check({core_clk_en, pll_en, internal_fast_rc_oscillator_en, external_fast_crystal_oscillator_en}, 0);
      check({main_regulator_en, low_power_regulator_en}, i % 2 ? 2'b01 : 2'b10);
      check({slow_clk_en, supply_voltage_detector_en}, 2'b11);
      fire(i[2:0]);
      wait_st(ST_RUN);
      axi_rd(WFLAG_OFS);
      check(rd[WF_STOP_BIT], 1'b1);
      axi_wr(WFLAG_OFS, 32'h0000_0001);
    end
    for (int j = 0; j < 4; j++) begin
      go_mode(32'h0000_0026, ST_STDBY);
      check({main_regulator_en, low_power_regulator_en, regulator_hiz, slow_clk_en}, 4'b0011);
      fire(j == 3 ? 3'd3 : 3'(4 + j));
      wait_st(ST_BOOT);
      @(posedge clock);
      check({core_reset, main_regulator_en}, 2'b11);
      wait_st(ST_RUN);
      // standby wake flag survives the boot sequence until software clears it
      axi_rd(WFLAG_OFS);
      check(rd[WF_STDBY_BIT], 1'b1);
      axi_wr(WFLAG_OFS, 32'h0000_0002);
      axi_rd(WFLAG_OFS);
      check(rd, 32'h0000_0000);
    end
    close_out();
  end
endmodule
